// File: core/i2c_master_tx.sv
// Purpose: I2C channel, master transmit with START, STOP and DMA refill.
// Assumes: Open-drain pins, enables high while pulling low.
// Notes: Slave transfers and reception are not built.
// Contract
// - Flags clear on write one; enables gate.
// - Start request drives START, sets two flags.
// - Empty buffer holds SCL low.
// - Written byte shifts out MSB first.
// - ACK sets empty flag; NACK sets NACK.
// - Stop request drives STOP, waits bus free.
// - Start after byte gives repeated START.
// - Empty flag raises enabled DMA requests.
// - Half SCL period is baud plus three.
// - SCL mismatch pauses the baud counter.
`include "i2c_tx_params.svh"
`timescale 1ns/1ps
`default_nettype none
module i2c_master_tx (
	input wire logic clk,
	input wire logic resetn,
	input wire logic moduleEnable,
	input wire logic masterSelect,
	input wire logic softResetBit,
	input wire logic [6:0] baudDivisor,
	input wire logic startRequestSet,
	input wire logic stopRequestSet,
	output logic startRequest,
	output logic stopRequest,
	input wire i2c_tx_pkg::flags_t flagClear,
	input wire i2c_tx_pkg::flags_t irqEnable,
	output i2c_tx_pkg::flags_t flags,
	output logic irq,
	input wire i2c_tx_pkg::byte_t txData,
	input wire logic txWrite,
	output logic txReady,
	input wire i2c_tx_pkg::dma_t txDmaRequestEnable,
	output i2c_tx_pkg::dma_t dmaRequest,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe
);
	import i2c_tx_pkg::*;

	localparam logic [7:0] BufLast = 8'(`I2C_BUF_CYCLES - 1);

	logic [1:0] rstSync;
	wire rstn = rstSync[1];
	logic [1:0] sdaSync;
	logic [1:0] sclSync;
	state_t state;
	state_t next_state;
	logic [7:0] cnt;
	logic [7:0] shift;
	logic [2:0] bitIdx;
	flags_t next_flags;
	flags_t setVec;
	byte_fifo_if fifoPort ();

	tx_fifo #(.WIDTH(`I2C_DATA_W), .DEPTH(`I2C_FIFO_DEPTH)) fifo (
		.clk(clk),
		.rstn(rstn),
		.port(fifoPort)
	);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rstSync <= 2'h0;
			sdaSync <= 2'h3;
			sclSync <= 2'h3;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
			sdaSync <= {sdaSync[0], sdaIn};
			sclSync <= {sclSync[0], sclIn};
		end
	end

	// Decoding of the current phase
	wire active = moduleEnable && masterSelect;
	wire sdaSensed = sdaSync[1];
	wire sclSensed = sclSync[1];
	wire inByte = (state == BIT_LOW) || (state == BIT_HIGH);
	wire sclLow = (state == HOLD) || (state == RS_LOW) || (state == BIT_LOW)
		|| (state == ACK_LOW) || (state == STOP_LOW);
	wire sdaLow = (inByte && !shift[7]) || (state == START_HOLD)
		|| (state == STOP_LOW) || (state == STOP_HIGH);
	// SDA moves only while SCL is sensed low, except START and STOP edges
	wire sdaFree = (sclLow && !sclSensed) || (state == IDLE) || (state == START_HOLD)
		|| (state == BUS_FREE);
	wire internalSclOut = !sclLow;
	wire stall = (internalSclOut != sclSensed) && (state != BUS_FREE);
	wire [7:0] halfLast = 8'(baudDivisor) + `I2C_BAUD_EXTRA - 8'h01;
	wire [7:0] target = (state == BUS_FREE) ? BufLast : halfLast;
	wire timed = (state != IDLE) && (state != HOLD);
	wire tick = timed && !stall && (cnt == target);
	wire holdFree = (state == HOLD) && !stopRequest && !startRequest;
	wire load = holdFree && fifoPort.outValid;
	wire ackSeen = (state == ACK_HIGH) && tick && !sdaSensed;
	wire nackSeen = (state == ACK_HIGH) && tick && sdaSensed;
	wire startDone = (state == START_HOLD) && tick;
	wire stopDone = (state == BUS_FREE) && tick;
	wire txeRise = setVec[`I2C_FLAG_TXE] && !flags[`I2C_FLAG_TXE];

	assign fifoPort.inData = txData;
	assign fifoPort.inValid = txWrite;
	assign fifoPort.outReady = load;
	assign fifoPort.flush = softResetBit;
	assign txReady = fifoPort.inReady;
	assign sdaOut = 1'b0;
	assign sclOut = 1'b0;

	always_comb begin
		setVec = `I2C_FLAG_RESET;
		setVec[`I2C_FLAG_START] = startDone;
		setVec[`I2C_FLAG_TXE] = startDone || ackSeen;
		setVec[`I2C_FLAG_NACK] = nackSeen;
		setVec[`I2C_FLAG_STOP] = stopDone;
		next_flags = (flags & ~flagClear) | setVec;
		if (load) begin
			next_flags[`I2C_FLAG_TXE] = 1'b0;
		end
	end

	always_comb begin
		next_state = state;
		unique case (state)
			IDLE: if (startRequest) next_state = START_HOLD;
			RS_LOW: if (tick) next_state = RS_HIGH;
			RS_HIGH: if (tick) next_state = START_HOLD;
			START_HOLD: if (tick) next_state = HOLD;
			HOLD: begin
				if (stopRequest) next_state = STOP_LOW;
				else if (startRequest) next_state = RS_LOW;
				else if (load) next_state = BIT_LOW;
			end
			BIT_LOW: if (tick) next_state = BIT_HIGH;
			BIT_HIGH: if (tick) next_state = (bitIdx == 3'h7) ? ACK_LOW : BIT_LOW;
			ACK_LOW: if (tick) next_state = ACK_HIGH;
			ACK_HIGH: if (tick) next_state = HOLD;
			STOP_LOW: if (tick) next_state = STOP_HIGH;
			STOP_HIGH: if (tick) next_state = BUS_FREE;
			BUS_FREE: if (tick) next_state = IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= IDLE;
			cnt <= 8'h00;
		end else if (!active || softResetBit) begin
			state <= IDLE;
			cnt <= 8'h00;
		end else begin
			state <= next_state;
			cnt <= (tick || !timed) ? 8'h00 : (stall ? cnt : cnt + 8'h01);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shift <= 8'h00;
			bitIdx <= 3'h0;
		end else if (load) begin
			shift <= fifoPort.outData;
			bitIdx <= 3'h0;
		end else if (state == BIT_HIGH && tick) begin
			shift <= {shift[6:0], 1'b0};
			bitIdx <= bitIdx + 3'h1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			startRequest <= 1'b0;
			stopRequest <= 1'b0;
		end else if (!active || softResetBit) begin
			startRequest <= 1'b0;
			stopRequest <= 1'b0;
		end else begin
			startRequest <= (startRequestSet || startRequest) && !startDone;
			stopRequest <= (stopRequestSet && state != IDLE || stopRequest) && !stopDone;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flags <= `I2C_FLAG_RESET;
			irq <= 1'b0;
			dmaRequest <= '0;
			sdaOe <= 1'b0;
			sclOe <= 1'b0;
		end else if (softResetBit) begin
			flags <= `I2C_FLAG_RESET;
			irq <= 1'b0;
			dmaRequest <= '0;
			sdaOe <= 1'b0;
			sclOe <= 1'b0;
		end else begin
			flags <= next_flags;
			irq <= |(next_flags & irqEnable);
			dmaRequest <= txDmaRequestEnable & {`I2C_DMA_CH{txeRise}};
			sdaOe <= active && (sdaFree ? sdaLow : sdaOe);
			sclOe <= active && sclLow;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn || softResetBit);

	sequence startPhase;
		state == START_HOLD && tick;
	endsequence
	sequence stopPhase;
		state == BUS_FREE && tick;
	endsequence

	flag_clear_a: assert property (flagClear[0] && !setVec[0] |=> !flags[0])
		else $error("Start flag not cleared by write one");
	start_done_a: assert property (startPhase |=> flags[`I2C_FLAG_START]
		&& flags[`I2C_FLAG_TXE] && !startRequest)
		else $error("START completion did not update flags");
	hold_low_a: assert property (state == HOLD && active |=> sclOe)
		else $error("SCL not held low while waiting");
	load_shift_a: assert property (load |=> state == BIT_LOW && bitIdx == 3'h0 ##[1:4]
		sdaOe == !shift[7])
		else $error("Byte not loaded into shifter");
	ack_flag_a: assert property (ackSeen && !load |=> flags[`I2C_FLAG_TXE])
		else $error("ACK did not set empty flag");
	nack_flag_a: assert property (nackSeen && !flags[`I2C_FLAG_TXE]
		|=> flags[`I2C_FLAG_NACK] && !flags[`I2C_FLAG_TXE])
		else $error("NACK handling wrong");
	stop_done_a: assert property (stopPhase |=> flags[`I2C_FLAG_STOP] && !stopRequest
		&& state == IDLE)
		else $error("STOP completion wrong");
	restart_a: assert property (state == HOLD && startRequest && !stopRequest && active
		|=> state == RS_LOW)
		else $error("Repeated START not begun");
	dma_req_a: assert property (txeRise |=> dmaRequest == $past(txDmaRequestEnable))
		else $error("DMA request missing");
	half_period_a: assert property (tick && state != BUS_FREE
		|-> cnt == 8'(baudDivisor) + 8'h02)
		else $error("SCL half period wrong");
	stretch_a: assert property (stall && timed && active |=> cnt == $past(cnt))
		else $error("Counter ran during SCL mismatch");
	disabled_a: assert property (!moduleEnable |=> state == IDLE ##1 !sdaOe && !sclOe)
		else $error("Disabled channel not idle");
endmodule : i2c_master_tx
`default_nettype wire

// File: core/tx_fifo.sv
// Purpose: Transmit byte FIFO.
// Assumes: Power-of-two depth.
// Notes: Flush empties it in one cycle.
`timescale 1ns/1ps
`default_nettype none
module tx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rstn,
	byte_fifo_if.fifo port
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr;
	logic [AW:0] rdPtr;
	wire full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
	wire empty = wrPtr == rdPtr;
	wire push = port.inValid && !full;
	wire pop = port.outReady && !empty;

	assign port.inReady = !full;
	assign port.outValid = !empty;
	assign port.outData = mem[rdPtr[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr[AW-1:0]] <= port.inData;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else if (port.flush) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			wrPtr <= wrPtr + (AW+1)'(push);
			rdPtr <= rdPtr + (AW+1)'(pop);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	no_overflow_a: assert property (full && !pop |=> $stable(wrPtr) || $past(port.flush))
		else $error("FIFO written while full");
endmodule : tx_fifo
`default_nettype wire

// File: pkg/byte_fifo_if.sv
// Purpose: Byte stream between channel and its transmit FIFO.
// Assumes: Single clock.
// Notes: Valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
interface byte_fifo_if;
	logic [7:0] inData;
	logic inValid;
	logic inReady;
	logic [7:0] outData;
	logic outValid;
	logic outReady;
	logic flush;
	modport fifo (input inData, inValid, outReady, flush, output inReady, outData, outValid);
	modport user (output inData, inValid, outReady, flush, input inReady, outData, outValid);
endinterface : byte_fifo_if
`default_nettype wire

// File: pkg/i2c_tx_params.svh
// Purpose: Constants of the master transmit channel.
// Assumes: 25 MHz system clock.
// Notes: Times in ns, counts derived from them.
`ifndef I2C_TX_PARAMS_SVH
`define I2C_TX_PARAMS_SVH
`define I2C_CLK_PERIOD_NS 40
`define I2C_T_BUF_NS 4700
`define I2C_BUF_CYCLES ((`I2C_T_BUF_NS + `I2C_CLK_PERIOD_NS - 1) / `I2C_CLK_PERIOD_NS)
`define I2C_BAUD_EXTRA 8'h03
`define I2C_DATA_W 8
`define I2C_FIFO_DEPTH 8
`define I2C_DMA_CH 16
`define I2C_FLAG_START 0
`define I2C_FLAG_TXE 1
`define I2C_FLAG_STOP 2
`define I2C_FLAG_NACK 3
`define I2C_FLAG_RESET 4'h0
`endif

// File: pkg/i2c_tx_pkg.sv
// Purpose: Types of the master transmit channel.
// Assumes: Nothing.
// Notes: States follow the bus phases.
package i2c_tx_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [3:0] flags_t;
	typedef logic [15:0] dma_t;
	typedef enum logic [3:0] {
		IDLE, RS_LOW, RS_HIGH, START_HOLD, HOLD, BIT_LOW, BIT_HIGH,
		ACK_LOW, ACK_HIGH, STOP_LOW, STOP_HIGH, BUS_FREE
	} state_t;
endpackage : i2c_tx_pkg

// File: tb/i2c_slave_model.sv
// Purpose: Behavioural I2C slave on open-drain lines.
// Assumes: Pull-ups on both lines.
// Notes: ACK or NACK on command, optional SCL stretch.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_model (
	input wire logic clk,
	input wire logic scl,
	input wire logic sda,
	input wire logic nackMode,
	input wire logic stretchMode,
	output logic sdaPull,
	output logic sclPull,
	output logic [7:0] lastByte
);
	logic [7:0] shiftIn = 8'h00;
	int bitCnt = 0;
	initial begin
		sdaPull = 1'b0;
		sclPull = 1'b0;
		lastByte = 8'h00;
	end
	// START resets the bit count
	always @(negedge sda) begin
		if (scl) begin
			bitCnt = 0;
			sdaPull = 1'b0;
		end
	end
	always @(posedge scl) begin
		if (bitCnt < 8)
			shiftIn = {shiftIn[6:0], sda};
		bitCnt = bitCnt + 1;
	end
	// Answer bit, then release
	always @(negedge scl) begin
		if (bitCnt == 8) begin
			lastByte = shiftIn;
			sdaPull = !nackMode;
			if (stretchMode) begin
				sclPull = 1'b1;
				repeat (40) @(posedge clk);
				sclPull <= 1'b0;
			end
		end else if (bitCnt == 9) begin
			sdaPull = 1'b0;
			bitCnt = 0;
		end
	end
endmodule : i2c_slave_model
`default_nettype wire

// File: tb/tb_i2c_master_tx.sv
// Purpose: Self-checking bench of the master transmit channel.
// Assumes: Slave model, pull-ups on both lines.
// Notes: START, bytes, FIFO, DMA, stretch, NACK, STOP.
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_master_tx;
	import i2c_tx_pkg::*;
	logic clk = 1'b0, resetn = 1'b0, moduleEnable = 1'b0, masterSelect = 1'b0;
	logic softResetBit = 1'b0, startRequestSet = 1'b0, stopRequestSet = 1'b0;
	logic txWrite = 1'b0, nackMode = 1'b0, stretchMode = 1'b0, measure = 1'b0;
	logic [6:0] baudDivisor = 7'h04;
	flags_t flagClear = 4'h0, irqEnable = 4'h0, flags;
	byte_t txData = 8'h00, lastByte;
	dma_t txDmaRequestEnable = 16'h0000, dmaRequest, dmaSeen = 16'h0000;
	logic startRequest, stopRequest, irq, txReady, sdaOe, sclOe, sdaPull, sclPull;
	logic sdaOut, sclOut;
	int err_count = 0, comparisons = 0, dur = 0, highCnt = 0, durA, hiA;
	wire logic sdaBus = !(sdaOe || sdaPull);
	wire logic sclBus = !(sclOe || sclPull);
	wire logic [5:0] status = {stopRequest, startRequest, flags};
	i2c_master_tx i2c_master_tx_inst (.clk(clk), .resetn(resetn),
		.moduleEnable(moduleEnable), .masterSelect(masterSelect),
		.softResetBit(softResetBit), .baudDivisor(baudDivisor),
		.startRequestSet(startRequestSet), .stopRequestSet(stopRequestSet),
		.startRequest(startRequest), .stopRequest(stopRequest), .flagClear(flagClear),
		.irqEnable(irqEnable), .flags(flags), .irq(irq), .txData(txData),
		.txWrite(txWrite), .txReady(txReady), .txDmaRequestEnable(txDmaRequestEnable),
		.dmaRequest(dmaRequest), .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.sclIn(sclBus), .sclOut(sclOut), .sclOe(sclOe));
	i2c_slave_model i2c_slave_model_inst (.clk(clk), .scl(sclBus), .sda(sdaBus),
		.nackMode(nackMode), .stretchMode(stretchMode), .sdaPull(sdaPull),
		.sclPull(sclPull), .lastByte(lastByte));
	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		dmaSeen <= resetn ? (dmaSeen | dmaRequest) : 16'h0000;
		if (measure) begin
			dur <= dur + 1;
			highCnt <= highCnt + int'(sclBus);
		end
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic final_report();
		if (err_count == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report
	task automatic ctl(input logic st, input logic sp, input flags_t clr);
		@(posedge clk);
		startRequestSet <= st;
		stopRequestSet <= sp;
		flagClear <= clr;
		@(posedge clk);
		startRequestSet <= 1'b0;
		stopRequestSet <= 1'b0;
		flagClear <= 4'h0;
		@(posedge clk);
	endtask : ctl
	task automatic waitBit(input int idx, input logic val);
		int n;
		n = 0;
		while (status[idx] !== val && n < 3000) begin
			@(posedge clk);
			n++;
		end
		check(16'(status[idx]), 16'(val));
	endtask : waitBit
	task automatic sendByte(input byte_t b, input int idx);
		@(posedge clk);
		txData <= b;
		txWrite <= 1'b1;
		dur <= 0;
		highCnt <= 0;
		measure <= 1'b1;
		@(posedge clk);
		txWrite <= 1'b0;
		waitBit(1, 1'b0);
		waitBit(idx, 1'b1);
		measure <= 1'b0;
	endtask : sendByte
	initial begin
		#800000;
		err_count++;
		final_report();
	end
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		check(16'({sdaOut, sclOut, flags, sdaOe, sclOe, startRequest, stopRequest, irq,
			txReady}), 16'h0001);
		ctl(1'b1, 1'b0, 4'h0);
		check(16'({startRequest, sdaOe, sclOe}), 16'h0000);
		softResetBit <= 1'b1;
		@(posedge clk);
		softResetBit <= 1'b0;
		moduleEnable <= 1'b1;
		ctl(1'b1, 1'b0, 4'h0);
		check(16'({startRequest, sdaOe, sclOe}), 16'h0000);
		moduleEnable <= 1'b0;
		irqEnable <= 4'h2;
		txDmaRequestEnable <= 16'h0008;
		ctl(1'b0, 1'b0, 4'hf);
		masterSelect <= 1'b1;
		softResetBit <= 1'b1;
		@(posedge clk);
		softResetBit <= 1'b0;
		moduleEnable <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			txData <= 8'h10 + 8'(i);
			txWrite <= 1'b1;
		end
		@(posedge clk);
		txWrite <= 1'b0;
		@(posedge clk);
		check(16'(txReady), 16'h0000);
		softResetBit <= 1'b1;
		@(posedge clk);
		softResetBit <= 1'b0;
		@(posedge clk);
		check(16'(txReady), 16'h0001);
		ctl(1'b1, 1'b0, 4'h0);
		waitBit(4, 1'b0);
		check(16'({irq, flags}), 16'h0013);
		repeat (20) @(posedge clk);
		check(dmaSeen, 16'h0008);
		check(16'(sclOe), 16'h0001);
		ctl(1'b0, 1'b0, 4'h1);
		check(16'(flags), 16'h0002);
		sendByte(8'ha4, 1);
		check(16'(lastByte), 16'h00a4);
		durA = dur;
		hiA = highCnt;
		baudDivisor <= 7'h09;
		sendByte(8'h5a, 1);
		check(16'(highCnt - hiA), 16'h002d);
		baudDivisor <= 7'h04;
		stretchMode <= 1'b1;
		sendByte(8'h3c, 1);
		check(16'(lastByte), 16'h003c);
		check(16'(dur >= durA + 20), 16'h0001);
		stretchMode <= 1'b0;
		ctl(1'b1, 1'b0, 4'h0);
		waitBit(4, 1'b0);
		check(16'(flags), 16'h0003);
		ctl(1'b0, 1'b0, 4'h1);
		nackMode <= 1'b1;
		sendByte(8'hc3, 3);
		check(16'(flags), 16'h0008);
		ctl(1'b0, 1'b0, 4'h8);
		ctl(1'b0, 1'b1, 4'h0);
		waitBit(5, 1'b0);
		check(16'({flags, sdaBus, sclBus}), 16'h0013);
		check(16'(irq), 16'h0000);
		final_report();
	end
endmodule : tb_i2c_master_tx
`default_nettype wire
